// ### bench/rsl_board_model.sv
`timescale 1ns/10ps
module rsl_board_model (
  input  wire       mclk_i,
  input  wire       rel_i,
  input  wire       num_i,
  input  wire [5:0] strap_n_i,
  input  wire [5:0] pin_drv_i,
  input  wire [5:0] pin_oe_n_i,
  input  wire       pull_i,
  output wire       rst_pin_n_o,
  output reg  [5:0] pin_lvl_o,
  output wire       busy_o
);
  reg [5:0] last_q = 6'h00;
  reg [2:0] cnt_q = 3'h0;
  integer   b;
  // reset pin low from time zero until the bench lets go, crystal assumed stable then
  assign rst_pin_n_o = rel_i;
  // busy high through reset, pulled low five clocks after release
  always @(posedge mclk_i) begin
    cnt_q <= !rel_i ? 3'h0 : (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
  end
  assign busy_o = !num_i || (cnt_q < 3'h5);
  // device drive wins; lock is never strapped low; floating lines wander
  always @* begin
    for (b = 0; b < 6; b = b + 1) begin
      if (!pin_oe_n_i[b]) pin_lvl_o[b] = pin_drv_i[b];
      else if (!strap_n_i[b] && b != 5) pin_lvl_o[b] = 1'b0;
      else if (pull_i) pin_lvl_o[b] = 1'b1;
      else pin_lvl_o[b] = ~last_q[b];
    end
  end
  // last level, so a floating line with no strap or pull-up never repeats itself
  always @(posedge mclk_i) begin
    last_q <= pin_lvl_o;
  end
endmodule

// ### bench/rsl_checker_assertions.sv
`timescale 1ns/10ps
module rsl_checker (
  input wire        mclk_i,
  input wire        rst_n_i,
  input wire        clk_en_i,
  input wire        reset_in_n_i,
  input wire        async_ready_i,
  input wire        sync_ready_i,
  input wire [5:0]  ctl_pins_i,
  input wire [5:0]  ctl_pins_o,
  input wire [5:0]  ctl_oe_n_o,
  input wire        wr_strobe_n_o,
  input wire        wr_strobe_oe_n_o,
  input wire        test_busy_i,
  input wire        pullup_en_o,
  input wire        core_rst_o,
  input wire        bus_done_o,
  input wire        wait_state_o,
  input wire        pin_float_test_mode_o,
  input wire        queue_status_mode_o,
  input wire        numerics_mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  reg [5:0] strap_q;
  // strap levels seen while the core is held in reset
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) strap_q <= 6'h3f;
    else if (core_rst_o) strap_q <= ctl_pins_i;
  end
  sequence drive_idle_s; ctl_pins_o == 6'h3f && ctl_oe_n_o == 6'h00 && wr_strobe_n_o; endsequence
  sequence float_s; ctl_oe_n_o == 6'h3f && wr_strobe_oe_n_o; endsequence
  abort_then_float_a: assert property ($fell(reset_in_n_i) && clk_en_i && ctl_oe_n_o != 6'h3f
    |-> ##[1:4] drive_idle_s ##[1:3] float_s) else $error("abort did not drive idle then float");
  core_reset_a: assert property ((clk_en_i && !reset_in_n_i) [*4] |-> core_rst_o)
    else $error("core not in reset while reset pin low");
  sync_delay_a: assert property ($fell(reset_in_n_i) && !core_rst_o |=> !core_rst_o)
    else $error("reset pin acted without synchroniser");
  pullup_float_a: assert property (core_rst_o [*4] |-> pullup_en_o && ctl_oe_n_o == 6'h3f && wr_strobe_oe_n_o)
    else $error("pins not pulled up inputs during reset");
  float_mode_a: assert property ($fell(core_rst_o) |-> ##2 pin_float_test_mode_o == (strap_q[2:1] == 2'b00))
    else $error("float mode does not follow selects");
  queue_mode_a: assert property ($fell(core_rst_o) |-> ##2 queue_status_mode_o == !strap_q[0])
    else $error("queue mode does not follow strap");
  numerics_mode_a: assert property ($fell(core_rst_o) |-> ##6 numerics_mode_o == ($past(test_busy_i, 7) && !test_busy_i))
    else $error("numerics mode wrong for busy sequence");
  mode_hold_a: assert property (!core_rst_o [*8] |-> $stable({pin_float_test_mode_o, queue_status_mode_o, numerics_mode_o}))
    else $error("latched modes changed outside reset");
  wait_cause_a: assert property (wait_state_o |-> !$past(sync_ready_i) && !$past(async_ready_i))
    else $error("wait state while a ready was high");
  ready_end_a: assert property (reset_in_n_i && (async_ready_i || sync_ready_i) &&
    (!ctl_pins_o[0] && !ctl_oe_n_o[0] || !wr_strobe_n_o && !wr_strobe_oe_n_o) |-> ##[1:3] bus_done_o)
    else $error("ready high did not end the cycle");
endmodule
bind rsl_reset_ready rsl_checker u_chk (.mclk_i, .rst_n_i, .clk_en_i, .reset_in_n_i, .async_ready_i, .sync_ready_i,
  .ctl_pins_i, .ctl_pins_o, .ctl_oe_n_o, .wr_strobe_n_o, .wr_strobe_oe_n_o, .test_busy_i, .pullup_en_o,
  .core_rst_o, .bus_done_o, .wait_state_o, .pin_float_test_mode_o, .queue_status_mode_o, .numerics_mode_o);

// ### bench/tb.sv
`timescale 1ns/10ps
`include "rsl_consts.vh"
module tb;
  reg         mclk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         clk_en_i = 1'b1;
  reg  [3:0]  reg_addr_i = 4'h0;
  reg  [15:0] reg_wdata_i = 16'h0000;
  reg         reg_wr_i = 1'b0;
  reg         reg_rd_i = 1'b0;
  reg         async_ready_i = 1'b0;
  reg         sync_ready_i = 1'b0;
  reg         rel = 1'b0;
  reg         num = 1'b0;
  reg  [5:0]  strap_n = 6'h3f;
  wire        reset_in_n_i, test_busy_i, wr_strobe_n_o, wr_strobe_oe_n_o, pullup_en_o, core_rst_o;
  wire        bus_done_o, wait_state_o, pin_float_test_mode_o, queue_status_mode_o, numerics_mode_o;
  wire [5:0]  ctl_pins_i, ctl_pins_o, ctl_oe_n_o;
  wire [15:0] reg_rdata_o;
  reg  [15:0] d;
  integer     n;
  integer     err_total = 0;
  integer     n_checks = 0;
  rsl_reset_ready uut (.mclk_i, .rst_n_i, .clk_en_i, .reset_in_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .async_ready_i, .sync_ready_i, .ctl_pins_i, .ctl_pins_o, .ctl_oe_n_o, .wr_strobe_n_o,
    .wr_strobe_oe_n_o, .test_busy_i, .pullup_en_o, .core_rst_o, .bus_done_o, .wait_state_o, .pin_float_test_mode_o,
    .queue_status_mode_o, .numerics_mode_o);
  rsl_board_model board (.mclk_i(mclk_i), .rel_i(rel), .num_i(num), .strap_n_i(strap_n), .pin_drv_i(ctl_pins_o),
    .pin_oe_n_i(ctl_oe_n_o), .pull_i(pullup_en_o), .rst_pin_n_o(reset_in_n_i), .pin_lvl_o(ctl_pins_i),
    .busy_o(test_busy_i));
  always #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] seen, input [15:0] exp, input [8*8-1:0] what);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge mclk_i);
  endtask
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  // read data is only valid in the cycle after the strobe
  task rd(input [3:0] a, output [15:0] v);
    begin
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
    end
  endtask
  // straps set well ahead of the release edge
  task hold_reset(input [5:0] s, input nv);
    begin
      @(posedge mclk_i);
      strap_n <= s;
      num <= nv;
      rel <= 1'b0;
      cyc(8);
      #1 chk({core_rst_o, pullup_en_o, wr_strobe_oe_n_o}, 16'h0007, "inreset");
      chk(ctl_oe_n_o, 16'h003f, "float");
      @(posedge mclk_i);
      rel <= 1'b1;
      cyc(12);
      strap_n <= 6'h3f;
    end
  endtask
  // one bus cycle; sync ready rises at step r, n counts clocks to the end pulse
  task run_cycle(input [15:0] ctl, input integer r);
    begin
      wr(`RSL_CTRL_OFS, ctl);
      #1 chk(ctl_pins_o, 16'h003d, "select");
      n = 0;
      while (bus_done_o !== 1'b1 && n < 40) begin
        @(posedge mclk_i);
        if (n == r) sync_ready_i <= 1'b1;
        #1 n = n + 1;
      end
      @(posedge mclk_i);
      sync_ready_i <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_power;
    begin
      hold_reset(6'h39, 1'b0);
      chk({pin_float_test_mode_o, queue_status_mode_o, numerics_mode_o}, 16'h0004, "modes");
      chk(ctl_oe_n_o, 16'h003f, "floatpin");
      rd(`RSL_STAT_OFS, d);
      chk(d, 16'h0008, "status");
    end
  endtask
  task t_clken;
    begin
      @(posedge mclk_i);
      clk_en_i <= 1'b0;
      rel <= 1'b0;
      cyc(6);
      #1 chk(core_rst_o, 16'h0000, "frozen");
      @(posedge mclk_i);
      clk_en_i <= 1'b1;
      cyc(5);
      #1 chk(core_rst_o, 16'h0001, "running");
      @(posedge mclk_i);
      rel <= 1'b1;
      cyc(12);
      chk(pin_float_test_mode_o, 16'h0000, "nofloat");
    end
  endtask
  task t_bus;
    begin
      run_cycle(16'h0001, 5);
      rd(`RSL_WCNT_OFS, d);
      chk(d, 16'(n - 3), "waits");
      chk(n > 3, 16'h0001, "waited");
      wr(`RSL_WCNT_OFS, 16'h0000);
      @(posedge mclk_i);
      async_ready_i <= 1'b1;
      run_cycle(16'h0003, 99);
      chk(16'(n), 16'h0003, "asyncend");
      rd(`RSL_WCNT_OFS, d);
      chk(d, 16'h0000, "nowait");
      @(posedge mclk_i);
      async_ready_i <= 1'b0;
      rd(4'hf, d);
      chk(d, 16'h0000, "unmapped");
    end
  endtask
  task t_abort;
    begin
      wr(`RSL_CTRL_OFS, 16'h0003);
      cyc(3);
      hold_reset(6'h3f, 1'b0);
      rd(`RSL_STAT_OFS, d);
      chk(d, 16'h0040, "aborted");
      wr(`RSL_STAT_OFS, 16'h0040);
      rd(`RSL_STAT_OFS, d);
      chk(d, 16'h0000, "cleared");
    end
  endtask
  task t_warm;
    begin
      hold_reset(6'h3e, 1'b1);
      cyc(4);
      chk({pin_float_test_mode_o, queue_status_mode_o, numerics_mode_o}, 16'h0003, "warmmode");
      rd(`RSL_STAT_OFS, d);
      chk(d, 16'h0030, "warmstat");
    end
  endtask
  task report_and_stop;
    begin
      if (err_total == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // the whole sequence needs well under a thousand clocks
  initial begin
    #200000;
    err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    cyc(4);
    rst_n_i <= 1'b1;
    t_power;
    t_clken;
    t_bus;
    t_abort;
    t_warm;
    report_and_stop;
  end
endmodule

// ### rtl/rsl_consts.vh
`ifndef RSL_CONSTS_VH
`define RSL_CONSTS_VH

// register offsets on the plain register port
`define RSL_CTRL_OFS      4'h0
`define RSL_STAT_OFS      4'h1
`define RSL_WCNT_OFS      4'h2

// control register fields
`define RSL_CTRL_GO       0
`define RSL_CTRL_WRITE    1
`define RSL_CTRL_SEL_LO   2
`define RSL_CTRL_SEL_HI   3
`define RSL_CTRL_LOCK     4
`define RSL_CTRL_RST      5'h00

// status register fields
`define RSL_STAT_CORE_RST 0
`define RSL_STAT_BUSY     1
`define RSL_STAT_WAIT     2
`define RSL_STAT_FLOAT    3
`define RSL_STAT_QUEUE    4
`define RSL_STAT_NUMERICS 5
`define RSL_STAT_ABORTED  6

// control pin bit positions
`define RSL_PIN_RD        0
`define RSL_PIN_UCS       1
`define RSL_PIN_LCS       2
`define RSL_PIN_MCS0      3
`define RSL_PIN_MCS1      4
`define RSL_PIN_LOCK      5
`define RSL_PINS_IDLE     6'h3f

// clocks from reset release to the second busy-pin sample
`define RSL_NUM_DELAY     3'd4

`endif

// ### rtl/rsl_reset_ready.v
`timescale 1ns/10ps
`include "rsl_consts.vh"

// Behaviour
// - The block holds the core in full reset for as long as the reset input is low.
// - The reset input passes a two-stage synchroniser on the processor clock before acting.
// - A warm reset returns the sequencer, control, count and mode registers to their initial state; the abort flag is kept.
// - A running bus cycle is aborted at once, pins driven inactive first and then floated.
// - During reset the strap pins are inputs held high by weak pull-ups.
// - Both memory selects low during reset selects pin-float test mode.
// - The queue-status strap low during reset selects queue status mode.
// - Busy pin high at reset and low four clocks later enables coprocessor mode.
// - Sync ready low with async ready low inserts a wait state in the current bus cycle.
// - Either ready input high ends the bus cycle.
module rsl_reset_ready #(
  parameter ADDR_W = 4,
  parameter DATA_W = 16
) (
  input  wire              mclk_i,
  input  wire              rst_n_i,
  input  wire              clk_en_i,
  input  wire              reset_in_n_i,
  input  wire [ADDR_W-1:0] reg_addr_i,
  input  wire [DATA_W-1:0] reg_wdata_i,
  input  wire              reg_wr_i,
  input  wire              reg_rd_i,
  output reg  [DATA_W-1:0] reg_rdata_o,
  input  wire              async_ready_i,
  input  wire              sync_ready_i,
  input  wire [5:0]        ctl_pins_i,
  output reg  [5:0]        ctl_pins_o,
  output reg  [5:0]        ctl_oe_n_o,
  output reg               wr_strobe_n_o,
  output reg               wr_strobe_oe_n_o,
  input  wire              test_busy_i,
  output reg               pullup_en_o,
  output reg               core_rst_o,
  output reg               bus_done_o,
  output reg               wait_state_o,
  output reg               pin_float_test_mode_o,
  output reg               queue_status_mode_o,
  output reg               numerics_mode_o
);

  // one-hot bus states
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_T1    = 7'h02;
  localparam [6:0] ST_T2    = 7'h04;
  localparam [6:0] ST_T3    = 7'h08;
  localparam [6:0] ST_T4    = 7'h10;
  localparam [6:0] ST_INACT = 7'h20;
  localparam [6:0] ST_FLOAT = 7'h40;

  // state meanings:
  //   idle  - no bus cycle, pins driven at their inactive levels
  //   t1    - select line for the chosen region pulled low
  //   t2    - read or write strobe goes low
  //   t3    - strobe held; waits here until either ready input is high
  //   t4    - strobes back high, done pulse raised
  //   inact - reset seen: every control pin driven inactive for one clock
  //   float - every control pin released so the board straps can be read
  // the float state is also the power-on state, so nothing is driven
  // until the core has been let out of reset at least once

  // reset synchroniser and its delayed copy for the release edge
  reg              rst_meta_q;
  reg              rst_sync_q;
  reg              core_rst_q;

  // bus sequencer
  reg  [6:0]       state_q;
  reg  [6:0]       state_d;

  // software-visible control, wait count and abort flag
  reg  [4:0]       ctrl_q;
  reg  [DATA_W-1:0] wcnt_q;
  reg              aborted_q;

  // strap samples and latched modes
  reg  [5:0]       strap_q;
  reg              busy_strap_q;
  reg  [2:0]       num_cnt_q;
  reg              num_arm_q;
  reg              float_mode_q;
  reg              queue_mode_q;
  reg              num_mode_q;

  // internal reset is the inverse of the synchronised pin; release_e
  // marks the single clock in which the core leaves reset, and is the
  // only moment at which the float and queue modes are set from the straps
  // internal reset level, high while the core is held
  wire             core_rst  = ~rst_sync_q;
  // one clock pulse as the core leaves reset
  wire             release_e = core_rst_q & ~core_rst;
  // either ready input ends t3
  wire             ready_any = async_ready_i | sync_ready_i;
  // a write of go to the control offset starts a cycle
  wire             go        = reg_wr_i && (reg_addr_i == `RSL_CTRL_OFS) && reg_wdata_i[`RSL_CTRL_GO];

  //////////////////////////////////////////////////////////////////////////
  // reset synchroniser; first stage feeds only the second
  // the pin is asynchronous to the core on a real board, so two flops keep
  // a metastable sample away from the sequencer; the cost is two clocks of
  // latency on both assertion and release
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
      core_rst_q <= 1'b1;
    end else if (clk_en_i) begin
      rst_meta_q <= reset_in_n_i;
      rst_sync_q <= rst_meta_q;
      // delayed copy, compared with core_rst to find the release clock
      core_rst_q <= core_rst;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (go)
          state_d = ST_T1;
      end
      ST_T1: begin
        state_d = ST_T2;
      end
      ST_T2: begin
        state_d = ST_T3;
      end
      // t3 repeats as a wait state until a ready input is seen high;
      // sync ready low with async ready low is what stretches the cycle
      ST_T3: begin
        if (ready_any)
          state_d = ST_T4;
      end
      ST_T4: begin
        state_d = ST_IDLE;
      end
      // one clock of inactive drive, then let go
      ST_INACT: begin
        state_d = ST_FLOAT;
      end
      // stays floated until reset is released
      ST_FLOAT: begin
        state_d = ST_FLOAT;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // reset overrides whatever the bus was doing: a running cycle is cut
    // off at once, one clock of inactive drive follows and then the pins
    // float; leaving reset always passes through idle so no cycle restarts
    // from stale state
    if (core_rst) begin
      if (state_q == ST_FLOAT)
        state_d = ST_FLOAT;
      else if (state_q == ST_INACT)
        state_d = ST_FLOAT;
      else
        state_d = ST_INACT;
    end else if (state_q == ST_INACT || state_q == ST_FLOAT) begin
      state_d = ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer state, control register and wait counter
  // control and count registers are forced back to zero for the whole of
  // reset, so software always finds them in their initial state; only the
  // abort flag survives, because it reports what reset interrupted
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= ST_FLOAT;
      ctrl_q    <= `RSL_CTRL_RST;
      wcnt_q    <= {DATA_W{1'b0}};
      aborted_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      if (core_rst) begin
        ctrl_q <= `RSL_CTRL_RST;
        wcnt_q <= {DATA_W{1'b0}};
        // remember a cut-short cycle for software after release
        if (state_q == ST_T1 || state_q == ST_T2 || state_q == ST_T3 || state_q == ST_T4)
          aborted_q <= 1'b1;
      end else begin
        if (reg_wr_i && reg_addr_i == `RSL_CTRL_OFS)
          ctrl_q <= reg_wdata_i[4:0];
        // the count only wraps, it never saturates; software clears it by
        // any write to its offset before a cycle it wants to measure
        if (reg_wr_i && reg_addr_i == `RSL_WCNT_OFS)
          wcnt_q <= {DATA_W{1'b0}};
        else if (state_q == ST_T3 && !ready_any && !sync_ready_i)
          wcnt_q <= wcnt_q + 1'b1;
        // hardware set wins over a software clear in the same cycle
        if (reg_wr_i && reg_addr_i == `RSL_STAT_OFS && reg_wdata_i[`RSL_STAT_ABORTED])
          aborted_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // strap capture while reset is held, latched at release
  // straps are sampled on every clock of reset so the last level before
  // release wins; the float and queue modes are set only on release_e, which
  // keeps them steady for the whole time the core runs
  // the busy pin is checked twice: high at release, low four clocks on
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_q      <= `RSL_PINS_IDLE;
      busy_strap_q <= 1'b1;
      float_mode_q <= 1'b0;
      queue_mode_q <= 1'b0;
      num_mode_q   <= 1'b0;
      num_arm_q    <= 1'b0;
      num_cnt_q    <= 3'd0;
    end else if (clk_en_i) begin
      if (core_rst) begin
        strap_q      <= ctl_pins_i;
        busy_strap_q <= test_busy_i;
        float_mode_q <= 1'b0;
        queue_mode_q <= 1'b0;
        num_mode_q   <= 1'b0;
        num_arm_q    <= 1'b0;
        num_cnt_q    <= 3'd0;
      end else if (release_e) begin
        // modes held from here until the next reset
        float_mode_q <= ~strap_q[`RSL_PIN_UCS] & ~strap_q[`RSL_PIN_LCS];
        queue_mode_q <= ~strap_q[`RSL_PIN_RD];
        num_arm_q    <= busy_strap_q;
        num_cnt_q    <= 3'd1;
      end else if (num_arm_q) begin
        if (num_cnt_q == `RSL_NUM_DELAY) begin
          num_mode_q <= ~test_busy_i;
          num_arm_q  <= 1'b0;
        end else begin
          num_cnt_q <= num_cnt_q + 3'd1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drive; inactive high before floating, float while in reset
  // all pin registers look at the next state, so a pin changes in the same
  // clock as the state that owns it and the outputs still come from flops
  // the select line is taken from the go write itself and then simply held
  // until t4 returns every pin to its inactive level
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_pins_o       <= `RSL_PINS_IDLE;
      ctl_oe_n_o       <= 6'h3f;
      wr_strobe_n_o    <= 1'b1;
      wr_strobe_oe_n_o <= 1'b1;
      pullup_en_o      <= 1'b1;
    end else if (clk_en_i) begin
      pullup_en_o <= core_rst;
      // pin-float mode releases every pin after reset as well, from the clock after release_e
      if (state_d == ST_FLOAT || (!core_rst && float_mode_q)) begin
        ctl_pins_o       <= `RSL_PINS_IDLE;
        ctl_oe_n_o       <= 6'h3f;
        wr_strobe_n_o    <= 1'b1;
        wr_strobe_oe_n_o <= 1'b1;
      end else if (state_d == ST_INACT || state_d == ST_IDLE || state_d == ST_T1 || state_d == ST_T4) begin
        ctl_pins_o       <= `RSL_PINS_IDLE;
        ctl_oe_n_o       <= 6'h00;
        wr_strobe_n_o    <= 1'b1;
        wr_strobe_oe_n_o <= 1'b0;
        if (state_d == ST_T1) begin
          ctl_pins_o[`RSL_PIN_UCS + reg_wdata_i[`RSL_CTRL_SEL_HI:`RSL_CTRL_SEL_LO]] <= 1'b0;
          ctl_pins_o[`RSL_PIN_LOCK] <= ~reg_wdata_i[`RSL_CTRL_LOCK];
        end
      end else begin
        // data phase of the cycle, held through wait states
        ctl_oe_n_o       <= 6'h00;
        wr_strobe_oe_n_o <= 1'b0;
        ctl_pins_o[`RSL_PIN_RD] <= ctrl_q[`RSL_CTRL_WRITE];
        wr_strobe_n_o           <= ~ctrl_q[`RSL_CTRL_WRITE];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status outputs
  // done and wait are judged on the registered state, so each shows for
  // exactly one clock per step of t3 and never while reset is active
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_rst_o            <= 1'b1;
      bus_done_o            <= 1'b0;
      wait_state_o          <= 1'b0;
      pin_float_test_mode_o <= 1'b0;
      queue_status_mode_o   <= 1'b0;
      numerics_mode_o       <= 1'b0;
    end else if (clk_en_i) begin
      core_rst_o            <= core_rst;
      bus_done_o            <= ~core_rst && state_q == ST_T3 && ready_any;
      wait_state_o          <= ~core_rst && state_q == ST_T3 && !ready_any;
      pin_float_test_mode_o <= float_mode_q;
      queue_status_mode_o   <= queue_mode_q;
      numerics_mode_o       <= num_mode_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe
  // reads have no side effects; clearing the abort flag takes a write
  // the data stand for one clock and fall back to zero, so a late sample
  // of the bus reads as zero instead of a stale word
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= {DATA_W{1'b0}};
    end else if (clk_en_i) begin
      reg_rdata_o <= {DATA_W{1'b0}};
      if (reg_rd_i) begin
        case (reg_addr_i)
          `RSL_CTRL_OFS: begin
            reg_rdata_o[4:0] <= ctrl_q;
          end
          `RSL_STAT_OFS: begin
            reg_rdata_o[`RSL_STAT_CORE_RST] <= core_rst;
            reg_rdata_o[`RSL_STAT_BUSY]     <= state_q != ST_IDLE;
            reg_rdata_o[`RSL_STAT_WAIT]     <= state_q == ST_T3;
            reg_rdata_o[`RSL_STAT_FLOAT]    <= float_mode_q;
            reg_rdata_o[`RSL_STAT_QUEUE]    <= queue_mode_q;
            reg_rdata_o[`RSL_STAT_NUMERICS] <= num_mode_q;
            reg_rdata_o[`RSL_STAT_ABORTED]  <= aborted_q;
          end
          `RSL_WCNT_OFS: begin
            reg_rdata_o <= wcnt_q;
          end
          default: begin
            reg_rdata_o <= {DATA_W{1'b0}};       // unmapped reads as zero
          end
        endcase
      end
    end
  end

endmodule
